// file: rtl/vcl_top.sv
// Purpose: VCO calibration limit registers with an AXI4-Lite slave port.
// Assumes: The calibration engine runs on i_ref_clk and pulses done for one cycle.
// Notes:   Results from a run overwrite any software write in the same cycle.
//
// Overview of operation
// - Integer lower-limit count is six bits, resets to 0x21, upper bits reserved.
// - Twenty-bit fraction count built from high nibble, middle byte, low byte.
// - Four-bit range code maps to offsets; codes above nine and three prohibited.
// - Seven-bit lower-limit result is readable, writable, and resets to 0x40.
// - A finished run started by the trigger stores the lower-limit result.
// - The finished run also stores the seven-bit upper-limit result, reset 0x40.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module vcl_top
    import vcl_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire vcl_cal_res_t      i_cal_res,
    output vcl_cal_cfg_t           o_cal_cfg
);

    if (ADDR_W < VCL_IDX_LSB + VCL_IDX_W)
    begin : g_chk
        $error("ADDR_W too small for the register index");
    end

    typedef struct packed {
        vcl_cal_cfg_t         cfg;
        logic                 aw_held;
        logic [VCL_IDX_W-1:0] aw_idx;
        logic                 w_held;
        logic [7:0]           wbyte;
        logic                 wlane0;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } vcl_state_t;

    vcl_state_t s_q;
    vcl_state_t s_d;

    logic                 commit;
    logic [VCL_IDX_W-1:0] ar_idx;
    logic [7:0]           rbyte;
    logic                 rhit;
    logic                 whit;

    assign commit = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign ar_idx = s_axi_araddr[VCL_IDX_LSB +: VCL_IDX_W];

    always_comb
    begin
        s_d   = s_q;
        rbyte = 8'h00;
        rhit  = 1'b1;
        whit  = 1'b1;
        s_d.cfg.start = 1'b0;

        // Read decode; reserved bits read as zero.
        if (ar_idx == VCL_IDX_LOW_INT)
            rbyte = {2'h0, s_q.cfg.int_cnt};
        else if (ar_idx == VCL_IDX_FRAC_HI)
            rbyte = {4'h0, s_q.cfg.frac_cnt[19:16]};
        else if (ar_idx == VCL_IDX_FRAC_MID)
            rbyte = s_q.cfg.frac_cnt[15:8];
        else if (ar_idx == VCL_IDX_FRAC_LO)
            rbyte = s_q.cfg.frac_cnt[7:0];
        else if (ar_idx == VCL_IDX_RANGE)
            rbyte = {4'h0, s_q.cfg.range_code};
        else if (ar_idx == VCL_IDX_LOW_RES)
            rbyte = {1'h0, s_q.cfg.low_res};
        else if (ar_idx == VCL_IDX_HIGH_RES)
            rbyte = {1'h0, s_q.cfg.high_res};
        else if (ar_idx == VCL_IDX_CAL_CTRL)
            rbyte = {6'h00, s_q.cfg.busy, 1'h0};
        else
            rhit = 1'b0;

        // Address and data are latched independently, in either order.
        if (s_axi_awvalid && s_q.awready)
        begin
            s_d.aw_held = 1'b1;
            s_d.aw_idx  = s_axi_awaddr[VCL_IDX_LSB +: VCL_IDX_W];
        end
        if (s_axi_wvalid && s_q.wready)
        begin
            s_d.w_held = 1'b1;
            s_d.wbyte  = s_axi_wdata[7:0];
            s_d.wlane0 = s_axi_wstrb[0];
        end

        if (commit)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            if (s_q.aw_idx == VCL_IDX_LOW_INT)
            begin
                if (s_q.wlane0) s_d.cfg.int_cnt = s_q.wbyte[5:0];
            end
            else if (s_q.aw_idx == VCL_IDX_FRAC_HI)
            begin
                if (s_q.wlane0) s_d.cfg.frac_cnt[19:16] = s_q.wbyte[3:0];
            end
            else if (s_q.aw_idx == VCL_IDX_FRAC_MID)
            begin
                if (s_q.wlane0) s_d.cfg.frac_cnt[15:8] = s_q.wbyte;
            end
            else if (s_q.aw_idx == VCL_IDX_FRAC_LO)
            begin
                if (s_q.wlane0) s_d.cfg.frac_cnt[7:0] = s_q.wbyte;
            end
            else if (s_q.aw_idx == VCL_IDX_RANGE)
            begin
                if (s_q.wlane0) s_d.cfg.range_code = s_q.wbyte[3:0];
            end
            else if (s_q.aw_idx == VCL_IDX_LOW_RES)
            begin
                if (s_q.wlane0) s_d.cfg.low_res = s_q.wbyte[6:0];
            end
            else if (s_q.aw_idx == VCL_IDX_HIGH_RES)
            begin
                if (s_q.wlane0) s_d.cfg.high_res = s_q.wbyte[6:0];
            end
            else if (s_q.aw_idx == VCL_IDX_CAL_CTRL)
            begin
                if (s_q.wlane0 && s_q.wbyte[VCL_CTRL_START_BIT] && !s_q.cfg.busy)
                begin
                    s_d.cfg.start = 1'b1;
                    s_d.cfg.busy  = 1'b1;
                end
            end
            else
                whit = 1'b0;
            s_d.bresp = whit ? VCL_RESP_OKAY : VCL_RESP_SLVERR;
        end
        else if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;

        if (s_axi_arvalid && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = {24'h000000, rbyte};
            s_d.rresp  = rhit ? VCL_RESP_OKAY : VCL_RESP_SLVERR;
        end
        else if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;

        // store low result after a run
        // store high result after a run
        if (i_cal_res.done && s_q.cfg.busy)
        begin
            s_d.cfg.low_res  = i_cal_res.low_code;
            s_d.cfg.high_res = i_cal_res.high_code;
            s_d.cfg.busy     = 1'b0;
        end

        s_d.cfg.range_steps = vcl_range_steps(s_d.cfg.range_code);
        s_d.cfg.range_bad   = (s_d.cfg.range_code == VCL_RANGE_GAP)
                            || (s_d.cfg.range_code > VCL_RANGE_MAX);

        // Ready is withheld while a beat is held, so nothing is ever dropped.
        s_d.awready = !s_d.aw_held && !s_d.bvalid;
        s_d.wready  = !s_d.w_held && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            s_q                  <= '0;
            s_q.cfg.int_cnt      <= VCL_RST_LOW_INT;
            s_q.cfg.frac_cnt     <= {VCL_RST_FRAC_HI, VCL_RST_FRAC_MID, VCL_RST_FRAC_LO};
            s_q.cfg.range_code   <= VCL_RST_RANGE;
            s_q.cfg.range_steps  <= VCL_STEPS_4;
            s_q.cfg.low_res      <= VCL_RST_RESULT;
            s_q.cfg.high_res     <= VCL_RST_RESULT;
        end
        else
            s_q <= s_d;
    end

    assign o_cal_cfg     = s_q.cfg;
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_int_reset;
        $past(i_rst) |-> o_cal_cfg.int_cnt == VCL_RST_LOW_INT;
    endproperty
    a_int_reset: assert property (p_int_reset) else $error("Integer count reset wrong");

    property p_frac_mid;
        commit && s_q.wlane0 && s_q.aw_idx == VCL_IDX_FRAC_MID
            |=> o_cal_cfg.frac_cnt[15:8] == $past(s_q.wbyte);
    endproperty
    a_frac_mid: assert property (p_frac_mid) else $error("Fraction middle byte lost");

    property p_range_top;
        o_cal_cfg.range_code == VCL_RANGE_MAX |-> o_cal_cfg.range_steps == VCL_STEPS_9;
    endproperty
    a_range_top: assert property (p_range_top) else $error("Range nine offset wrong");

    property p_range_bad;
        o_cal_cfg.range_bad == ((o_cal_cfg.range_code == VCL_RANGE_GAP)
                                || (o_cal_cfg.range_code > VCL_RANGE_MAX));
    endproperty
    a_range_bad: assert property (p_range_bad) else $error("Prohibited code flag wrong");

    property p_low_reset;
        $past(i_rst) |-> o_cal_cfg.low_res == VCL_RST_RESULT;
    endproperty
    a_low_reset: assert property (p_low_reset) else $error("Low result reset wrong");

    property p_start_busy;
        o_cal_cfg.start |-> o_cal_cfg.busy ##1 !o_cal_cfg.start;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("Start pulse malformed");

    property p_low_store;
        i_cal_res.done && o_cal_cfg.busy |=> o_cal_cfg.low_res == $past(i_cal_res.low_code);
    endproperty
    a_low_store: assert property (p_low_store) else $error("Low result not stored");

    property p_high_store;
        i_cal_res.done && o_cal_cfg.busy
            |=> o_cal_cfg.high_res == $past(i_cal_res.high_code) && !o_cal_cfg.busy;
    endproperty
    a_high_store: assert property (p_high_store) else $error("High result not stored");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("Write response dropped");

    property p_cv_write;
        s_axi_bvalid && s_axi_bready && s_axi_bresp == VCL_RESP_OKAY;
    endproperty
    c_cv_write: cover property (p_cv_write);

    property p_cv_read;
        s_axi_rvalid && s_axi_rready && s_axi_rresp == VCL_RESP_OKAY;
    endproperty
    c_cv_read: cover property (p_cv_read);

    property p_cv_run;
        o_cal_cfg.start ##[1:50] (i_cal_res.done && o_cal_cfg.busy);
    endproperty
    c_cv_run: cover property (p_cv_run);

endmodule

// file: pkg/vcl_pkg.sv
// Purpose: Shared constants and carriers for the VCO calibration limit block.
// Assumes: Registers are 8-bit fields, each placed in one aligned 32-bit word.
// Notes:   Register indices are word indices; the byte address is four times the index.
package vcl_pkg;

    // Register indices.
    localparam logic [7:0] VCL_IDX_LOW_INT  = 8'h4D;
    localparam logic [7:0] VCL_IDX_FRAC_HI  = 8'h4E;
    localparam logic [7:0] VCL_IDX_FRAC_MID = 8'h4F;
    localparam logic [7:0] VCL_IDX_FRAC_LO  = 8'h50;
    localparam logic [7:0] VCL_IDX_RANGE    = 8'h51;
    localparam logic [7:0] VCL_IDX_LOW_RES  = 8'h52;
    localparam logic [7:0] VCL_IDX_HIGH_RES = 8'h53;
    localparam logic [7:0] VCL_IDX_CAL_CTRL = 8'h6F;

    // Address slicing: a word index sits above the two byte-offset bits.
    localparam int VCL_IDX_LSB = 2;
    localparam int VCL_IDX_W   = 8;

    // Reset values of the fields.
    localparam logic [5:0] VCL_RST_LOW_INT  = 6'h21;
    localparam logic [3:0] VCL_RST_FRAC_HI  = 4'h4;
    localparam logic [7:0] VCL_RST_FRAC_MID = 8'hEC;
    localparam logic [7:0] VCL_RST_FRAC_LO  = 8'h4E;
    localparam logic [3:0] VCL_RST_RANGE    = 4'h4;
    localparam logic [6:0] VCL_RST_RESULT   = 7'h40;

    // Control register bit positions.
    localparam int VCL_CTRL_START_BIT = 0;
    localparam int VCL_CTRL_BUSY_BIT  = 1;

    // Upper-range codes, and the offset expressed in steps of 0.8125 MHz.
    localparam logic [3:0] VCL_RANGE_GAP  = 4'h3;
    localparam logic [3:0] VCL_RANGE_MAX  = 4'h9;
    localparam logic [7:0] VCL_STEPS_0    = 8'h00;
    localparam logic [7:0] VCL_STEPS_1    = 8'h01;
    localparam logic [7:0] VCL_STEPS_2    = 8'h02;
    localparam logic [7:0] VCL_STEPS_4    = 8'h08;
    localparam logic [7:0] VCL_STEPS_5    = 8'h10;
    localparam logic [7:0] VCL_STEPS_6    = 8'h20;
    localparam logic [7:0] VCL_STEPS_7    = 8'h40;
    localparam logic [7:0] VCL_STEPS_8    = 8'h66;
    localparam logic [7:0] VCL_STEPS_9    = 8'h80;

    // Bus responses.
    localparam logic [1:0] VCL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] VCL_RESP_SLVERR = 2'h2;

    // Result of a calibration run, from the calibration engine.
    typedef struct packed {
        logic       done;
        logic [6:0] low_code;
        logic [6:0] high_code;
    } vcl_cal_res_t;

    // Settings handed to the synthesizer and calibration engine.
    typedef struct packed {
        logic [5:0]  int_cnt;
        logic [19:0] frac_cnt;
        logic [3:0]  range_code;
        logic [7:0]  range_steps;
        logic        range_bad;
        logic        start;
        logic        busy;
        logic [6:0]  low_res;
        logic [6:0]  high_res;
    } vcl_cal_cfg_t;

    // Maps an upper-range code to its offset in 0.8125 MHz steps.
    function automatic logic [7:0] vcl_range_steps(input logic [3:0] code);
        logic [7:0] s;
        s = VCL_STEPS_0;
        case (code)
            4'h1: s = VCL_STEPS_1;
            4'h2: s = VCL_STEPS_2;
            4'h4: s = VCL_STEPS_4;
            4'h5: s = VCL_STEPS_5;
            4'h6: s = VCL_STEPS_6;
            4'h7: s = VCL_STEPS_7;
            4'h8: s = VCL_STEPS_8;
            4'h9: s = VCL_STEPS_9;
            default: s = VCL_STEPS_0;
        endcase
        return s;
    endfunction

endpackage

// file: dv/vcl_top_tb.sv
// Purpose: Self-checking bench for the calibration limit registers over AXI4-Lite.
// Assumes: Single clock, synchronous active-high reset, results arrive as a done pulse.
// Notes:   Expected values come from the register map, never from the design outputs.
`timescale 1ns/100ps
module vcl_top_tb;
    import vcl_pkg::*;

    logic               clk, rst;
    logic [11:0]        awaddr, araddr;
    logic               awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    vcl_cal_res_t       cal_res;
    vcl_cal_cfg_t       cal_cfg;
    int                 bad_count, n_tests, start_cnt;
    logic [7:0]         steps_tab [16];

    vcl_top #(.ADDR_W(12)) i_dut (
        .i_ref_clk(clk), .i_rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .i_cal_res(cal_res), .o_cal_cfg(cal_cfg)
    );

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Counting start pulses avoids sampling a one-cycle output in a racy time step.
    always @(posedge clk)
    begin
        if (!rst && cal_cfg.start === 1'h1)
            start_cnt++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] dat, input logic [1:0] rexp);
        logic a_done, w_done, got;
        a_done = 1'h0;
        w_done = 1'h0;
        got = 1'h0;
        @(posedge clk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, dat};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // Only the watchdog ends a wait, so a missing answer shows up as a failure.
        while (!got)
        begin
            @(posedge clk);
            if (!a_done && awready)
            begin
                a_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready)
            begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
            if (bvalid)
            begin
                got = 1'h1;
                bready <= 1'h0;
                check({30'h0, bresp}, {30'h0, rexp}, "write response");
            end
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] rexp);
        logic got;
        got = 1'h0;
        @(posedge clk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!got)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid)
            begin
                got = 1'h1;
                rready <= 1'h0;
                check(rdata, {24'h0, exp}, "read data");
                check({30'h0, rresp}, {30'h0, rexp}, "read response");
            end
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    initial
    begin
        steps_tab = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h08, 8'h10, 8'h20, 8'h40,
                      8'h66, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        cal_res = '0;
        rst = 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(8'h4D, 8'h21, 2'h0);
        rd(8'h4E, 8'h04, 2'h0);
        rd(8'h4F, 8'hEC, 2'h0);
        rd(8'h50, 8'h4E, 2'h0);
        rd(8'h51, 8'h04, 2'h0);
        rd(8'h52, 8'h40, 2'h0);
        rd(8'h53, 8'h40, 2'h0);
        check({12'h0, cal_cfg.frac_cnt}, 32'h0004EC4E, "fraction at reset");
        // Reserved bits are written high and must read back low.
        wr(8'h4D, 8'hFF, 2'h0);
        wr(8'h4E, 8'hFA, 2'h0);
        wr(8'h4F, 8'h55, 2'h0);
        wr(8'h50, 8'hA3, 2'h0);
        rd(8'h4D, 8'h3F, 2'h0);
        rd(8'h4E, 8'h0A, 2'h0);
        #1;
        check({26'h0, cal_cfg.int_cnt}, 32'h0000003F, "integer count");
        check({12'h0, cal_cfg.frac_cnt}, 32'h000A55A3, "fraction count");
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h51, {4'hF, c[3:0]}, 2'h0);
            rd(8'h51, {4'h0, c[3:0]}, 2'h0);
            #1;
            check({24'h0, cal_cfg.range_steps}, {24'h0, steps_tab[c]}, "range steps");
            check({31'h0, cal_cfg.range_bad}, (c == 3 || c > 9) ? 32'h1 : 32'h0, "bad");
        end
        // A legal code whose span covers the intended operating point.
        wr(8'h51, 8'h05, 2'h0);
        rd(8'h51, 8'h05, 2'h0);
        #1;
        check({24'h0, cal_cfg.range_steps}, 32'h00000010, "covering range");
        check({31'h0, cal_cfg.range_bad}, 32'h00000000, "covering range legal");
        wr(8'h52, 8'hFF, 2'h0);
        rd(8'h52, 8'h7F, 2'h0);
        wr(8'h53, 8'h95, 2'h0);
        rd(8'h53, 8'h15, 2'h0);
        // A write with byte lane zero disabled is answered but changes nothing.
        wstrb <= 4'hE;
        wr(8'h52, 8'h11, 2'h0);
        rd(8'h52, 8'h7F, 2'h0);
        wstrb <= 4'hF;
        wr(8'h54, 8'h12, 2'h2);
        rd(8'h54, 8'h00, 2'h2);
        // A done pulse with no run in progress must leave the low result alone.
        @(posedge clk);
        cal_res <= {1'h1, 7'h01, 7'h02};
        @(posedge clk);
        cal_res <= '0;
        rd(8'h52, 8'h7F, 2'h0);
        wr(8'h6F, 8'h01, 2'h0);
        #1;
        check(start_cnt, 1, "start pulses");
        wr(8'h6F, 8'h01, 2'h0);
        rd(8'h6F, 8'h02, 2'h0);
        #1;
        check(start_cnt, 1, "start ignored while busy");
        @(posedge clk);
        cal_res <= {1'h1, 7'h2B, 7'h6C};
        @(posedge clk);
        cal_res <= '0;
        rd(8'h52, 8'h2B, 2'h0);
        rd(8'h53, 8'h6C, 2'h0);
        rd(8'h6F, 8'h00, 2'h0);
        #1;
        check({25'h0, cal_cfg.low_res}, 32'h0000002B, "low result output");
        check({25'h0, cal_cfg.high_res}, 32'h0000006C, "high result output");
        // A second reset after the run has finished must restore every field after the writes above.
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(8'h4D, 8'h21, 2'h0);
        rd(8'h52, 8'h40, 2'h0);
        rd(8'h53, 8'h40, 2'h0);
        #1;
        check({12'h0, cal_cfg.frac_cnt}, 32'h0004EC4E, "fraction after reset");
        check({28'h0, cal_cfg.range_code}, 32'h00000004, "range after reset");
        print_verdict();
    end
endmodule
